// ---- rtl/dci_defs.svh ----
// Constants for the disc control interface block.
`ifndef DCI_DEFS_SVH
`define DCI_DEFS_SVH
`define DCI_CLK_NS 20
`define DCI_BIT_NS 1330
`define DCI_BIT_CYC ((`DCI_BIT_NS + `DCI_CLK_NS - 1) / `DCI_CLK_NS)
`define DCI_TICK_W 7
`define DCI_BUS_W 36
`define DCI_SEL_W 7
`define DCI_ADR_IN_W 19
`define DCI_ACC_W 20
`define DCI_ADR_W 21
`define DCI_BSC_W 5
`define DCI_CHR_W 18
`define DCI_CCNT_W 5
`define DCI_CBUF_W 11
`define DCI_CM_MASK 11'h600
`define DCI_CM_LOW 9
`define DCI_SEQ_W 8
`define DCI_TSW_W 4
`define DCI_ERR_W 6
`define DCI_STAT_PAD (`DCI_BUS_W - `DCI_CBUF_W - `DCI_SEQ_W - `DCI_ERR_W - `DCI_TSW_W)
`define DCI_DIN_PAD (`DCI_BUS_W - `DCI_ACC_W - `DCI_BSC_W)
`endif

// ---- rtl/dci_pkg.sv ----
// Types shared by the disc control interface block.
package dci_pkg;
`include "dci_defs.svh"
	typedef logic [`DCI_BSC_W-1:0]  dci_bsc_t;
	typedef logic [`DCI_TICK_W-1:0] dci_tick_t;
	typedef logic [`DCI_CCNT_W-1:0] dci_ccnt_t;
	typedef logic [`DCI_CBUF_W-1:0] dci_cbuf_t;
	typedef enum logic [1:0] {
		DCI_SER_IDLE  = 2'b01,
		DCI_SER_SHIFT = 2'b10
	} dci_ser_e;
	typedef struct packed {
		logic bus_rst, ctl_clr, ctl_set, dat_clr, dat_set, stat_lvl, din_lvl;
		logic wclk_even, wclk_odd, even_one, even_zero, odd_one, odd_zero;
		logic out_done, attached, unit_err, lockout, alarm, operable, mclr_btn;
	} dci_pin_s;
	typedef struct packed {
		logic [`DCI_SEL_W-1:0]    sel;
		logic [`DCI_ADR_IN_W-1:0] data;
		logic [`DCI_CHR_W-1:0]    chr;
		logic [`DCI_TSW_W-1:0]    tsw;
	} dci_word_s;
	typedef struct packed {
		logic sel, alert, rd, wr, fin, clr;
	} dci_disc_s;
	typedef struct packed {
		logic e1, e0, o1, o0;
	} dci_rail_s;
	typedef struct packed {
		logic [`DCI_STAT_PAD-1:0] pad;
		logic [`DCI_CBUF_W-1:0]   cbuf;
		logic [`DCI_SEQ_W-1:0]    seq;
		logic rail_err, attach_err, unit_err, lockout, alarm, operable;
		logic [`DCI_TSW_W-1:0]    tsw;
	} dci_stat_s;
	typedef struct packed {
		logic [`DCI_DIN_PAD-1:0] pad;
		logic [`DCI_ACC_W-1:0]   acc;
		logic [`DCI_BSC_W-1:0]   bsc;
	} dci_din_s;
endpackage

// ---- rtl/dci_sync.sv ----
// Two-flop synchroniser with rising-edge detect, one lane per bit.
`timescale 1ns/1ns
module dci_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Asynchronous inputs and their synchronised forms.
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o,
	output logic      [W-1:0] rise_o
);
	genvar g;
	generate
		if (W < 1) begin : g_chk
			$error("dci_sync width must be at least one");
		end
		for (g = 0; g < W; g++) begin : g_lane
			logic meta_reg;
			logic sync_reg;
			logic last_reg;
			// The meta flop feeds only the second flop.
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
					last_reg <= 1'b0;
				end else begin
					meta_reg <= d_i[g];
					sync_reg <= meta_reg;
					last_reg <= sync_reg;
				end
			end
			// Level and edge seen in the core domain.
			assign q_o[g]    = sync_reg;
			assign rise_o[g] = sync_reg & ~last_reg;
		end
	endgenerate
endmodule

// ---- rtl/dci_top.sv ----
// Disc control interface: processor bus, data channel and disc unit signalling.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`include "dci_defs.svh"
module dci_top
	import dci_pkg::*;
#(
	parameter logic [`DCI_SEL_W-1:0] DEV_CODE = 7'h15, // Arbitrary value.
	parameter int                    BIT_CYC  = `DCI_BIT_CYC
) (
	// Clock and reset.
	input  wire logic                     CORE_CLK_I,
	input  wire logic                     SRST_I,
	// Processor bus.
	input  wire logic                     BUS_RESET_I,
	input  wire logic [`DCI_SEL_W-1:0]    DEV_SEL_I,
	input  wire logic                     CTL_OUT_CLR_I,
	input  wire logic                     CTL_OUT_SET_I,
	input  wire logic                     DATA_OUT_CLR_I,
	input  wire logic                     DATA_OUT_SET_I,
	input  wire logic                     STATUS_IN_I,
	input  wire logic                     DATA_IN_I,
	input  wire logic [`DCI_ADR_IN_W-1:0] BUS_ADDR_BITS_I,
	input  wire logic [`DCI_TSW_W-1:0]    TEST_SW_I,
	output logic      [`DCI_BUS_W-1:0]    BUS_DATA_O,
	output logic                          BUS_DRIVE_N_O,
	output logic                          DEV_MATCH_O,
	// Sequencer side.
	input  wire logic [`DCI_SEQ_W-1:0]    SEQ_STATE_I,
	input  wire logic                     CHG_CMD_EN_I,
	input  wire logic                     ADDR_SEND_I,
	input  wire logic                     SEQ_ALERT_I,
	input  wire logic                     SEQ_CMD_I,
	input  wire logic                     SEQ_END_I,
	input  wire logic                     SEQ_CLEAR_I,
	input  wire logic                     WRITE_ACTIVE_I,
	input  wire logic                     READ_ACTIVE_I,
	output logic      [`DCI_CBUF_W-1:0]   CMD_BUF_O,
	output logic                          FILE_CTL_CLR_O,
	output logic                          ACCUM_LOAD_O,
	output logic                          ADDR_DONE_O,
	output logic                          DATA_END_O,
	output logic                          CHAN_ERR_O,
	// Data channel.
	input  wire logic [`DCI_CHR_W-1:0]    CHAN_CHAR_I,
	input  wire logic                     CHAN_OUT_DONE_I,
	input  wire logic                     CHAN_ATTACHED_I,
	output logic      [`DCI_CHR_W-1:0]    CHAN_CHAR_O,
	output logic                          GIVE_CHAR_O,
	output logic                          TAKE_CHAR_O,
	// Disc unit.
	input  wire logic                     WCLK_EVEN_I,
	input  wire logic                     WCLK_ODD_I,
	input  wire logic                     EVEN_ONE_I,
	input  wire logic                     EVEN_ZERO_I,
	input  wire logic                     ODD_ONE_I,
	input  wire logic                     ODD_ZERO_I,
	input  wire logic                     UNIT_ERR_I,
	input  wire logic                     LOCKOUT_I,
	input  wire logic                     ALARM_I,
	input  wire logic                     OPERABLE_I,
	input  wire logic                     MCLR_BTN_I,
	output logic                          SELECT_O,
	output logic                          ALERT_O,
	output logic                          READ_O,
	output logic                          WRITE_O,
	output logic                          END_O,
	output logic                          CLEAR_O,
	output logic                          DRIVE_MCLR_O,
	output logic                          EVEN_ONE_O,
	output logic                          EVEN_ZERO_O,
	output logic                          ODD_ONE_O,
	output logic                          ODD_ZERO_O
);
	generate
		if (BIT_CYC < 1 || BIT_CYC > (1 << `DCI_TICK_W)) begin : g_chk
			$error("BIT_CYC does not fit the bit timer");
		end
	endgenerate

	// All pins except the sequencer-side inputs pass the synchronisers before any logic looks at them.
	dci_pin_s  pin_raw, pin_s, pin_r;
	dci_word_s word_raw, word_s;
	assign pin_raw = {BUS_RESET_I, CTL_OUT_CLR_I, CTL_OUT_SET_I, DATA_OUT_CLR_I,
		DATA_OUT_SET_I, STATUS_IN_I, DATA_IN_I, WCLK_EVEN_I, WCLK_ODD_I,
		EVEN_ONE_I, EVEN_ZERO_I, ODD_ONE_I, ODD_ZERO_I, CHAN_OUT_DONE_I,
		CHAN_ATTACHED_I, UNIT_ERR_I, LOCKOUT_I, ALARM_I, OPERABLE_I, MCLR_BTN_I};
	assign word_raw = {DEV_SEL_I, BUS_ADDR_BITS_I, CHAN_CHAR_I, TEST_SW_I};
	dci_sync #(.W($bits(dci_pin_s))) u_pin (
		.clk_i  (CORE_CLK_I),
		.rst_i  (SRST_I),
		.d_i    (pin_raw),
		.q_o    (pin_s),
		.rise_o (pin_r)
	);
	dci_sync #(.W($bits(dci_word_s))) u_word (
		.clk_i  (CORE_CLK_I),
		.rst_i  (SRST_I),
		.d_i    (word_raw),
		.q_o    (word_s),
		.rise_o ()
	);

	// Bus decode: internal reset fans out into four clears, and every
	// instruction pulse is qualified by the device match.
	logic match_reg, match_next;
	logic bus_reset_pulse, cmd_buffer_clear_pulse, cmd_load_pulse;
	logic accum_clear_pulse, accum_load_pulse, file_ctl_clear_pulse;
	logic seq_clear_pulse, status_gate_pulse, accum_gate_pulse;
	assign match_next             = (word_s.sel == DEV_CODE);
	assign bus_reset_pulse        = pin_r.bus_rst;
	assign cmd_buffer_clear_pulse = bus_reset_pulse | (pin_r.ctl_clr & match_reg);
	assign cmd_load_pulse         = pin_r.ctl_set & match_reg & ~bus_reset_pulse;
	assign accum_clear_pulse      = bus_reset_pulse | (pin_r.dat_clr & match_reg);
	assign accum_load_pulse       = pin_r.dat_set & match_reg & ~bus_reset_pulse;
	assign file_ctl_clear_pulse   = bus_reset_pulse;
	assign seq_clear_pulse        = bus_reset_pulse;
	assign status_gate_pulse      = pin_s.stat_lvl & match_reg;
	assign accum_gate_pulse       = pin_s.din_lvl & match_reg;

	// Command buffer and address accumulator.
	dci_cbuf_t cmd_reg, cmd_next;
	logic [`DCI_ACC_W-1:0] acc_reg, acc_next;
	logic cm_ok;
	always_comb begin
		cm_ok    = CHG_CMD_EN_I | bus_reset_pulse;
		cmd_next = cmd_reg;
		acc_next = acc_reg;
		if (cmd_buffer_clear_pulse) begin
			cmd_next = cm_ok ? '0 : (cmd_reg & `DCI_CM_MASK);
		end
		if (cmd_load_pulse) begin
			cmd_next = cm_ok ? (cmd_next | word_s.data[`DCI_CBUF_W-1:0])
				: (cmd_next | (word_s.data[`DCI_CBUF_W-1:0] & ~`DCI_CM_MASK));
		end
		if (accum_clear_pulse) begin
			acc_next = '0;
		end else if (accum_load_pulse) begin
			acc_next = acc_reg | {1'b0, word_s.data};
		end
	end
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			match_reg <= 1'b0;
			cmd_reg   <= '0;
			acc_reg   <= '0;
		end else begin
			match_reg <= match_next;
			cmd_reg   <= cmd_next;
			acc_reg   <= acc_next;
		end
	end

	// Address serialiser: 21 bits, low bit first, parity last.
	dci_ser_e ser_reg, ser_next;
	logic [`DCI_ADR_W-1:0] ash_reg, ash_next;
	dci_bsc_t bsc_reg, bsc_next;
	dci_tick_t tick_reg, tick_next;
	logic ser_emit, ser_bit, done_next;
	always_comb begin
		ser_next  = ser_reg;
		ash_next  = ash_reg;
		bsc_next  = bsc_reg;
		tick_next = tick_reg;
		ser_emit  = 1'b0;
		ser_bit   = ash_reg[0];
		done_next = 1'b0;
		case (ser_reg)
			DCI_SER_IDLE: begin
			end
			DCI_SER_SHIFT: begin
				if (tick_reg != '0) begin
					tick_next = tick_reg - dci_tick_t'(1);
				end else begin
					ser_emit  = 1'b1;
					ash_next  = ash_reg >> 1;
					bsc_next  = bsc_reg + dci_bsc_t'(1);
					tick_next = dci_tick_t'(BIT_CYC - 1);
					if (bsc_reg == dci_bsc_t'(`DCI_ADR_W - 1)) begin
						ser_next  = DCI_SER_IDLE;
						done_next = 1'b1;
					end
				end
			end
			default: ser_next = DCI_SER_IDLE;
		endcase
		if (ADDR_SEND_I) begin
			ser_next  = DCI_SER_SHIFT;
			ash_next  = {~^acc_reg, acc_reg};
			bsc_next  = '0;
			tick_next = '0;
		end
		if (file_ctl_clear_pulse) begin
			ser_next = DCI_SER_IDLE;
		end
		if (accum_clear_pulse) begin
			bsc_next = '0;
		end
	end
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			ser_reg  <= DCI_SER_IDLE;
			ash_reg  <= '0;
			bsc_reg  <= '0;
			tick_reg <= '0;
		end else begin
			ser_reg  <= ser_next;
			ash_reg  <= ash_next;
			bsc_reg  <= bsc_next;
			tick_reg <= tick_next;
		end
	end

	// Write path: one character bit per write clock, give after each take-in.
	logic [`DCI_CHR_W-1:0] wsh_reg, wsh_next;
	dci_ccnt_t wcnt_reg, wcnt_next;
	logic wr_emit, wr_bit, wr_odd, give_next;
	always_comb begin
		wsh_next  = wsh_reg;
		wcnt_next = wcnt_reg;
		give_next = 1'b0;
		wr_emit   = WRITE_ACTIVE_I & (pin_r.wclk_even | pin_r.wclk_odd);
		wr_odd    = ~pin_r.wclk_even;
		wr_bit    = wsh_reg[0];
		if (!WRITE_ACTIVE_I || seq_clear_pulse) begin
			wcnt_next = '0;
		end else if (wr_emit) begin
			if (wcnt_reg == '0) begin
				wr_bit    = word_s.chr[0];
				wsh_next  = word_s.chr >> 1;
				wcnt_next = dci_ccnt_t'(`DCI_CHR_W - 1);
				give_next = 1'b1;
			end else begin
				wsh_next  = wsh_reg >> 1;
				wcnt_next = wcnt_reg - dci_ccnt_t'(1);
			end
		end
	end

	// Outgoing rails: address bits and write bits share the dual-rail lines.
	dci_rail_s rail_reg, rail_next;
	always_comb begin
		rail_next = '0;
		if (ser_emit) begin
			rail_next.e1 = ~bsc_reg[0] & ser_bit;
			rail_next.e0 = ~bsc_reg[0] & ~ser_bit;
			rail_next.o1 = bsc_reg[0] & ser_bit;
			rail_next.o0 = bsc_reg[0] & ~ser_bit;
		end else if (wr_emit) begin
			rail_next.e1 = ~wr_odd & wr_bit;
			rail_next.e0 = ~wr_odd & ~wr_bit;
			rail_next.o1 = wr_odd & wr_bit;
			rail_next.o0 = wr_odd & ~wr_bit;
		end
	end

	// Read path: assemble a character from the incoming rails.
	logic [`DCI_CHR_W-1:0] rsh_reg, rsh_next, chr_reg, chr_next;
	dci_ccnt_t rcnt_reg, rcnt_next;
	logic take_pend_reg, take_pend_next, rd_one, rd_zero;
	always_comb begin
		rsh_next       = rsh_reg;
		rcnt_next      = rcnt_reg;
		chr_next       = chr_reg;
		take_pend_next = 1'b0;
		rd_one         = pin_r.even_one | pin_r.odd_one;
		rd_zero        = pin_r.even_zero | pin_r.odd_zero;
		if (!READ_ACTIVE_I || seq_clear_pulse) begin
			rcnt_next = '0;
		end else if (rd_one ^ rd_zero) begin
			rsh_next = {rd_one, rsh_reg[`DCI_CHR_W-1:1]};
			if (rcnt_reg == dci_ccnt_t'(`DCI_CHR_W - 1)) begin
				chr_next       = rsh_next;
				rcnt_next      = '0;
				take_pend_next = 1'b1;
			end else begin
				rcnt_next = rcnt_reg + dci_ccnt_t'(1);
			end
		end
	end

	// Error flags and channel end detect; a set beats a clear.
	logic attach_err_reg, attach_err_next, rail_err_reg, rail_err_next, dend_next;
	always_comb begin
		attach_err_next = (attach_err_reg & ~seq_clear_pulse)
			| (SEQ_CMD_I & ~pin_s.attached);
		rail_err_next   = (rail_err_reg & ~seq_clear_pulse)
			| (READ_ACTIVE_I & rd_one & rd_zero);
		dend_next       = WRITE_ACTIVE_I & pin_r.out_done;
	end

	// Disc unit control pulses.
	dci_disc_s disc_reg, disc_next;
	logic alerted_reg, alerted_next;
	always_comb begin
		disc_next       = '0;
		alerted_next    = alerted_reg;
		disc_next.sel   = accum_load_pulse;
		disc_next.alert = SEQ_ALERT_I;
		if (SEQ_ALERT_I) begin
			alerted_next = 1'b1;
		end
		if (SEQ_CMD_I && alerted_reg) begin
			disc_next.rd = cmd_reg[`DCI_CM_LOW];
			disc_next.wr = ~cmd_reg[`DCI_CM_LOW];
			alerted_next = 1'b0;
		end
		disc_next.fin = SEQ_END_I | SEQ_CLEAR_I;
		disc_next.clr = SEQ_CLEAR_I;
		if (file_ctl_clear_pulse) begin
			alerted_next = 1'b0;
		end
	end

	// Bus read-back during the status and data-in levels.
	dci_stat_s stat_w;
	dci_din_s din_w;
	logic [`DCI_BUS_W-1:0] bus_next;
	logic drive_n_next;
	always_comb begin
		stat_w = '{pad: '0, cbuf: cmd_reg, seq: SEQ_STATE_I, rail_err: rail_err_reg,
			attach_err: attach_err_reg, unit_err: pin_s.unit_err, lockout: pin_s.lockout,
			alarm: pin_s.alarm, operable: pin_s.operable, tsw: word_s.tsw};
		din_w        = '{pad: '0, acc: acc_reg, bsc: bsc_reg};
		bus_next     = '0;
		drive_n_next = 1'b1;
		if (status_gate_pulse) begin
			bus_next     = stat_w;
			drive_n_next = 1'b0;
		end else if (accum_gate_pulse) begin
			bus_next     = din_w;
			drive_n_next = 1'b0;
		end
	end

	// Registers of the data paths and of the top-level outputs not assigned below.
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			wsh_reg        <= '0;
			wcnt_reg       <= '0;
			rsh_reg        <= '0;
			rcnt_reg       <= '0;
			chr_reg        <= '0;
			take_pend_reg  <= 1'b0;
			attach_err_reg <= 1'b0;
			rail_err_reg   <= 1'b0;
			alerted_reg    <= 1'b0;
			disc_reg       <= '0;
			rail_reg       <= '0;
			BUS_DATA_O     <= '0;
			BUS_DRIVE_N_O  <= 1'b1;
			GIVE_CHAR_O    <= 1'b0;
			TAKE_CHAR_O    <= 1'b0;
			ADDR_DONE_O    <= 1'b0;
			DATA_END_O     <= 1'b0;
			ACCUM_LOAD_O   <= 1'b0;
			FILE_CTL_CLR_O <= 1'b0;
			DRIVE_MCLR_O   <= 1'b0;
		end else begin
			wsh_reg        <= wsh_next;
			wcnt_reg       <= wcnt_next;
			rsh_reg        <= rsh_next;
			rcnt_reg       <= rcnt_next;
			chr_reg        <= chr_next;
			take_pend_reg  <= take_pend_next;
			attach_err_reg <= attach_err_next;
			rail_err_reg   <= rail_err_next;
			alerted_reg    <= alerted_next;
			disc_reg       <= disc_next;
			rail_reg       <= rail_next;
			BUS_DATA_O     <= bus_next;
			BUS_DRIVE_N_O  <= drive_n_next;
			GIVE_CHAR_O    <= give_next;
			TAKE_CHAR_O    <= take_pend_reg;
			ADDR_DONE_O    <= done_next;
			DATA_END_O     <= dend_next;
			ACCUM_LOAD_O   <= accum_load_pulse;
			FILE_CTL_CLR_O <= file_ctl_clear_pulse;
			DRIVE_MCLR_O   <= pin_s.mclr_btn;
		end
	end

	// Outputs that are registers in their own right.
	assign DEV_MATCH_O = match_reg;
	assign CMD_BUF_O   = cmd_reg;
	assign CHAN_ERR_O  = attach_err_reg;
	assign CHAN_CHAR_O = chr_reg;
	assign SELECT_O    = disc_reg.sel;
	assign ALERT_O     = disc_reg.alert;
	assign READ_O      = disc_reg.rd;
	assign WRITE_O     = disc_reg.wr;
	assign END_O       = disc_reg.fin;
	assign CLEAR_O     = disc_reg.clr;
	assign EVEN_ONE_O  = rail_reg.e1;
	assign EVEN_ZERO_O = rail_reg.e0;
	assign ODD_ONE_O   = rail_reg.o1;
	assign ODD_ZERO_O  = rail_reg.o0;

	// Cycles since the last address bit, so the spacing check works for any BIT_CYC.
	logic [`DCI_TICK_W:0] gap_reg, gap_next;
	logic gap_arm_reg, gap_arm_next;
	always_comb begin
		gap_next     = gap_reg;
		gap_arm_next = gap_arm_reg;
		if (ser_emit) begin
			gap_next     = '0;
			gap_arm_next = 1'b1;
		end else if (gap_reg != '1) begin
			gap_next = gap_reg + 1'b1;
		end
		if (ADDR_SEND_I || file_ctl_clear_pulse) begin
			gap_arm_next = 1'b0;
		end
	end
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			gap_reg     <= '0;
			gap_arm_reg <= 1'b0;
		end else begin
			gap_reg     <= gap_next;
			gap_arm_reg <= gap_arm_next;
		end
	end

	// Checks on the behaviour above.
	AST_RESET_CLEARS: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		bus_reset_pulse |=> (cmd_reg == '0) && (acc_reg == '0) && FILE_CTL_CLR_O)
		else $error("bus reset did not clear the block");
	AST_NO_MATCH_IGNORED: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		(pin_r.ctl_set && !match_reg && !pin_r.ctl_clr && !bus_reset_pulse)
		|=> $stable(cmd_reg))
		else $error("command buffer changed without device match");
	AST_ACC_LOAD: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		(accum_load_pulse && !accum_clear_pulse && acc_reg == '0)
		|=> acc_reg == {1'b0, $past(word_s.data)})
		else $error("accumulator did not load bus bits");
	AST_CM_LOCKED: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		((cmd_load_pulse || cmd_buffer_clear_pulse) && !CHG_CMD_EN_I && !bus_reset_pulse)
		|=> $stable(cmd_reg & `DCI_CM_MASK))
		else $error("command code changed while disabled");
	AST_STATUS_DRIVE: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		status_gate_pulse |=> !BUS_DRIVE_N_O && BUS_DATA_O[`DCI_BUS_W-`DCI_STAT_PAD-1:
		`DCI_BUS_W-`DCI_STAT_PAD-`DCI_CBUF_W] == $past(cmd_reg))
		else $error("status word not driven");
	AST_CLEAR_WITH_END: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		CLEAR_O |-> END_O)
		else $error("clear pulse sent without end pulse");
	AST_ONE_RAIL: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		!(EVEN_ONE_O && EVEN_ZERO_O) && !(ODD_ONE_O && ODD_ZERO_O)
		&& !((EVEN_ONE_O || EVEN_ZERO_O) && (ODD_ONE_O || ODD_ZERO_O)))
		else $error("more than one rail line pulsed");
	AST_BIT_SPACING: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		(ser_emit && gap_arm_reg) |-> int'(gap_reg) == BIT_CYC - 1)
		else $error("address bits closer than the bit period");
	AST_TAKE_AFTER_CHAR: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		take_pend_next |=> ##1 TAKE_CHAR_O && $stable(CHAN_CHAR_O))
		else $error("take pulse missing after character");
	AST_CMD_NEEDS_ALERT: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
		(READ_O || WRITE_O) |-> $past(alerted_reg, 1))
		else $error("command pulse without alert");
endmodule

// ---- verif/dci_disc_model.sv ----
// Disc unit model: write clocks and status levels toward the controller.
`timescale 1ns/1ns
module dci_disc_model (
	// Control from the bench.
	input  wire logic       en_i,
	// Lines toward the controller.
	output logic            wclk_even_o,
	output logic            wclk_odd_o,
	output logic      [3:0] stat_o
);
	// Error, lockout and alarm stay clear; the unit reports operable.
	assign stat_o = 4'h1;
	// Alternating even and odd write clocks, one per bit, only while a sector is written.
	initial begin
		wclk_even_o = 1'b0;
		wclk_odd_o = 1'b0;
		forever begin
			if (!en_i) begin
				wait (en_i);
				#5;
			end
			#80 wclk_even_o = 1'b1;
			#80 wclk_even_o = 1'b0;
			if (en_i) begin
				#80 wclk_odd_o = 1'b1;
				#80 wclk_odd_o = 1'b0;
			end
		end
	end
endmodule

// ---- verif/dci_top_tb.sv ----
// Self-checking bench for the disc control interface block.
`timescale 1ns/1ns
module dci_top_tb;
	logic CORE_CLK_I, SRST_I, BUS_RESET_I, CTL_OUT_CLR_I, CTL_OUT_SET_I, DATA_OUT_CLR_I;
	logic DATA_OUT_SET_I, STATUS_IN_I, DATA_IN_I, CHG_CMD_EN_I, ADDR_SEND_I, SEQ_ALERT_I;
	logic SEQ_CMD_I, SEQ_END_I, SEQ_CLEAR_I, WRITE_ACTIVE_I, READ_ACTIVE_I, CHAN_OUT_DONE_I;
	logic CHAN_ATTACHED_I, EVEN_ONE_I, EVEN_ZERO_I, ODD_ONE_I, ODD_ZERO_I, MCLR_BTN_I, wen;
	logic [6:0] DEV_SEL_I;
	logic [18:0] BUS_ADDR_BITS_I;
	logic [3:0] TEST_SW_I;
	logic [7:0] SEQ_STATE_I;
	logic [17:0] CHAN_CHAR_I, CHAN_CHAR_O;
	logic [35:0] BUS_DATA_O;
	logic [10:0] CMD_BUF_O;
	logic BUS_DRIVE_N_O, DEV_MATCH_O, FILE_CTL_CLR_O, ACCUM_LOAD_O, ADDR_DONE_O, DATA_END_O;
	logic CHAN_ERR_O, GIVE_CHAR_O, TAKE_CHAR_O, SELECT_O, ALERT_O, READ_O, WRITE_O, END_O;
	logic CLEAR_O, DRIVE_MCLR_O, EVEN_ONE_O, EVEN_ZERO_O, ODD_ONE_O, ODD_ZERO_O;
	wire WCLK_EVEN_I, WCLK_ODD_I, UNIT_ERR_I, LOCKOUT_I, ALARM_I, OPERABLE_I;
	wire [3:0] rail = {EVEN_ONE_O, EVEN_ZERO_O, ODD_ONE_O, ODD_ZERO_O};
	int err_count, num_checks, cnt [11], g;
	dci_top #(.DEV_CODE(7'h15)) i_dci_top (.CORE_CLK_I, .SRST_I, .BUS_RESET_I,
		.DEV_SEL_I, .CTL_OUT_CLR_I, .CTL_OUT_SET_I, .DATA_OUT_CLR_I, .DATA_OUT_SET_I,
		.STATUS_IN_I, .DATA_IN_I, .BUS_ADDR_BITS_I, .TEST_SW_I, .BUS_DATA_O, .BUS_DRIVE_N_O,
		.DEV_MATCH_O, .SEQ_STATE_I, .CHG_CMD_EN_I, .ADDR_SEND_I, .SEQ_ALERT_I, .SEQ_CMD_I,
		.SEQ_END_I, .SEQ_CLEAR_I, .WRITE_ACTIVE_I, .READ_ACTIVE_I, .CMD_BUF_O, .FILE_CTL_CLR_O,
		.ACCUM_LOAD_O, .ADDR_DONE_O, .DATA_END_O, .CHAN_ERR_O, .CHAN_CHAR_I, .CHAN_OUT_DONE_I,
		.CHAN_ATTACHED_I, .CHAN_CHAR_O, .GIVE_CHAR_O, .TAKE_CHAR_O, .WCLK_EVEN_I, .WCLK_ODD_I,
		.EVEN_ONE_I, .EVEN_ZERO_I, .ODD_ONE_I, .ODD_ZERO_I, .UNIT_ERR_I, .LOCKOUT_I, .ALARM_I,
		.OPERABLE_I, .MCLR_BTN_I, .SELECT_O, .ALERT_O, .READ_O, .WRITE_O, .END_O, .CLEAR_O,
		.DRIVE_MCLR_O, .EVEN_ONE_O, .EVEN_ZERO_O, .ODD_ONE_O, .ODD_ZERO_O);
	dci_disc_model i_dci_disc_model (.en_i(wen), .wclk_even_o(WCLK_EVEN_I),
		.wclk_odd_o(WCLK_ODD_I), .stat_o({UNIT_ERR_I, LOCKOUT_I, ALARM_I, OPERABLE_I}));
	// 50 MHz core clock.
	initial begin
		CORE_CLK_I = 1'b0;
		forever #10 CORE_CLK_I = ~CORE_CLK_I;
	end
	// Pulse counters, sampled mid-cycle where registered outputs have settled.
	always @(negedge CORE_CLK_I) begin
		if (ACCUM_LOAD_O === 1'b1 && SELECT_O === 1'b1) cnt[0]++;
		if (FILE_CTL_CLR_O === 1'b1) cnt[1]++;
		if (ALERT_O === 1'b1) cnt[2]++;
		if (READ_O === 1'b1) cnt[3]++;
		if (WRITE_O === 1'b1) cnt[4]++;
		if (CLEAR_O === 1'b1 && END_O === 1'b1) cnt[5]++;
		if (GIVE_CHAR_O === 1'b1) cnt[6]++;
		if (ADDR_DONE_O === 1'b1) cnt[7]++;
		if (DATA_END_O === 1'b1) cnt[8]++;
		if (END_O === 1'b1) cnt[9]++;
		if (TAKE_CHAR_O === 1'b1) cnt[10]++;
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge CORE_CLK_I);
	endtask
	task automatic chk(input logic [36:0] got, input logic [36:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Raise one input for n cycles, then hold it low for n cycles.
	task automatic pulse(input int k, input int n);
		for (int v = 1; v >= 0; v--) begin
			case (k)
				0: CTL_OUT_CLR_I <= v[0];
				1: CTL_OUT_SET_I <= v[0];
				2: DATA_OUT_CLR_I <= v[0];
				3: DATA_OUT_SET_I <= v[0];
				4: BUS_RESET_I <= v[0];
				5: SEQ_ALERT_I <= v[0];
				6: SEQ_CMD_I <= v[0];
				7: SEQ_CLEAR_I <= v[0];
				8: ADDR_SEND_I <= v[0];
				default: SEQ_END_I <= v[0];
			endcase
			tick(n);
		end
	endtask
	// Hold a read level and compare the word driven onto the bus.
	task automatic rd(input logic st, input logic [35:0] e);
		STATUS_IN_I <= st;
		DATA_IN_I <= ~st;
		tick(5);
		chk({BUS_DRIVE_N_O, BUS_DATA_O}, {1'b0, e});
		STATUS_IN_I <= 1'b0;
		DATA_IN_I <= 1'b0;
		tick(5);
		chk(BUS_DRIVE_N_O, 1);
	endtask
	// Wait, bounded, for a pulse on any outgoing data line.
	task automatic wait_rail;
		g = 0;
		do begin
			@(negedge CORE_CLK_I);
			g++;
			if (g > 200) begin
				err_count++;
				report_and_stop();
			end
		end while (rail === 4'h0);
	endtask
	function automatic logic [3:0] rl(input int i, input logic b);
		return (i % 2) ? {2'b00, b, ~b} : {b, ~b, 2'b00};
	endfunction
	task automatic t_data;
		cnt = '{default: 0};
		DEV_SEL_I <= 7'h15;
		BUS_ADDR_BITS_I <= 19'h5_A5C3;
		tick(6);
		chk(DEV_MATCH_O, 1);
		pulse(2, 4);
		pulse(3, 4);
		chk(cnt[0], 1);
		rd(1'b0, {11'h0, 1'b0, 19'h5_A5C3, 5'h0});
		DEV_SEL_I <= 7'h14;
		tick(6);
		chk(DEV_MATCH_O, 0);
		pulse(2, 4);
		pulse(1, 4);
		chk(CMD_BUF_O, 11'h000);
		DEV_SEL_I <= 7'h15;
		tick(6);
		rd(1'b0, {11'h0, 1'b0, 19'h5_A5C3, 5'h0});
		$display("data out test done");
	endtask
	task automatic t_ctl;
		BUS_ADDR_BITS_I <= 19'h0_07FF;
		pulse(0, 4);
		pulse(1, 4);
		chk(CMD_BUF_O, 11'h1FF);
		CHG_CMD_EN_I <= 1'b1;
		pulse(0, 4);
		chk(CMD_BUF_O, 11'h000);
		BUS_ADDR_BITS_I <= 19'h0_02AB;
		pulse(1, 4);
		chk(CMD_BUF_O, 11'h2AB);
		rd(1'b1, {7'h0, 11'h2AB, 8'hC3, 10'h01A});
		$display("control out test done");
	endtask
	task automatic t_addr;
		logic [20:0] e;
		e = {~^19'h5_A5C3, 1'b0, 19'h5_A5C3};
		cnt = '{default: 0};
		pulse(8, 1);
		for (int i = 0; i < 21; i++) begin
			wait_rail();
			chk(rail, rl(i, e[i]));
			if (i > 0) chk(g, 67);
		end
		tick(3);
		chk(cnt[7], 1);
		$display("address test done");
	endtask
	task automatic t_disc;
		cnt = '{default: 0};
		CHAN_ATTACHED_I <= 1'b0;
		tick(4);
		pulse(6, 1);
		tick(3);
		chk(cnt[3] + cnt[4], 0);
		chk(CHAN_ERR_O, 1);
		CHAN_ATTACHED_I <= 1'b1;
		pulse(5, 1);
		pulse(6, 1);
		pulse(7, 1);
		pulse(9, 1);
		tick(3);
		chk(cnt[2], 1);
		chk(cnt[3], 1);
		chk(cnt[4], 0);
		chk(cnt[5], 1);
		chk(cnt[9], 2);
		// Clear the code bits so the next command is a write, then restore.
		pulse(0, 4);
		pulse(5, 1);
		pulse(6, 1);
		tick(3);
		chk(cnt[4], 1);
		pulse(1, 4);
		$display("disc control test done");
	endtask
	task automatic t_write;
		cnt = '{default: 0};
		CHAN_CHAR_I <= 18'h2_D3C5;
		WRITE_ACTIVE_I <= 1'b1;
		tick(5);
		wen <= 1'b1;
		for (int i = 0; i < 18; i++) begin
			wait_rail();
			chk(rail, rl(i, 18'h2_D3C5 >> i));
		end
		wen <= 1'b0;
		tick(2);
		CHAN_OUT_DONE_I <= 1'b1;
		tick(6);
		chk(cnt[6], 1);
		chk(cnt[8], 1);
		CHAN_OUT_DONE_I <= 1'b0;
		WRITE_ACTIVE_I <= 1'b0;
		$display("write test done");
	endtask
	task automatic t_read;
		logic [17:0] c;
		c = 18'h1_2D4B;
		cnt = '{default: 0};
		READ_ACTIVE_I <= 1'b1;
		tick(2);
		for (int i = 0; i < 18; i++) begin
			{EVEN_ONE_I, EVEN_ZERO_I, ODD_ONE_I, ODD_ZERO_I} <= rl(i, c[i]);
			tick(3);
			{EVEN_ONE_I, EVEN_ZERO_I, ODD_ONE_I, ODD_ZERO_I} <= 4'h0;
			tick(3);
		end
		tick(4);
		chk(CHAN_CHAR_O, c);
		chk(cnt[10], 1);
		READ_ACTIVE_I <= 1'b0;
		$display("read test done");
	endtask
	task automatic t_reset;
		cnt = '{default: 0};
		pulse(4, 4);
		chk(cnt[1], 1);
		chk(CMD_BUF_O, 11'h000);
		MCLR_BTN_I <= 1'b1;
		tick(6);
		chk(DRIVE_MCLR_O, 1);
		$display("reset test done");
	endtask
	// Main sequence: quiet inputs, reset for 16 cycles, then each scenario.
	initial begin
		{SRST_I, CHAN_ATTACHED_I} = 2'b11;
		{BUS_RESET_I, CTL_OUT_CLR_I, CTL_OUT_SET_I, DATA_OUT_CLR_I, DATA_OUT_SET_I} = '0;
		{STATUS_IN_I, DATA_IN_I, CHG_CMD_EN_I, ADDR_SEND_I, SEQ_ALERT_I, SEQ_CMD_I} = '0;
		{SEQ_END_I, SEQ_CLEAR_I, WRITE_ACTIVE_I, READ_ACTIVE_I, CHAN_OUT_DONE_I} = '0;
		{EVEN_ONE_I, EVEN_ZERO_I, ODD_ONE_I, ODD_ZERO_I, MCLR_BTN_I, wen} = '0;
		{DEV_SEL_I, BUS_ADDR_BITS_I, CHAN_CHAR_I} = '0;
		TEST_SW_I = 4'hA;
		SEQ_STATE_I = 8'hC3;
		tick(16);
		SRST_I <= 1'b0;
		tick(1);
		t_data();
		t_ctl();
		t_addr();
		t_disc();
		t_write();
		t_read();
		t_reset();
		report_and_stop();
	end
endmodule
